// file: logic/external_memory_bus_interface.sv
// external memory and i/o bus interface: space selects, strobes, waits, hold
// assumes synchronous pin inputs; a pad ring resolves the output enables
//
// Summary of operation
// [RULE1] a space select goes low only while its space is accessed
// [RULE2] memory strobe low only for data or program accesses
// [RULE3] i/o strobe low only for i/o accesses
// [RULE4] read-not-write stays high except during writes
// [RULE5] low ready stretches the access; ready is rechecked every cycle
// [RULE6] ready counts only with two or more waits, after they end
// [RULE7] wait-complete goes low during the last software wait; the code strobes it only when two or more waits are set
// [RULE8] wait-complete looped to ready adds exactly one wait
// [RULE9] another master requests the bus with hold; lines then float
// [RULE10] hold acknowledge low only while in hold with lines floated
// [RULE11] hold acknowledge driven high during reset
// [RULE12] hold floats selects, strobes and direction
// [RULE13] float-all low floats every bus output
// [RULE14] instruction-fetch low when an instruction address is out
// [RULE15] after reset the first fetch comes from 0ff80h
// [RULE16] strap low maps internal rom high; high sends it external
// [RULE17] strap taken only at reset; software may override it
// [RULE18] low sixteen address lines always; upper seven for program only
// [RULE19] data bus floats unless writing, in reset or in hold
// [RULE20] bus keepers off after reset, software switches them
// [RULE21] at most one select, always with its strobe
// [RULE22] hold granted only between accesses
//
// Strobed register access and the address map are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module external_memory_bus_interface (
  input  wire logic                              core_clk,
  input  wire logic                              rst_n,
  input  wire logic                              req_valid,
  output logic                                   req_ready,
  input  wire logic [1:0]                        req_space,
  input  wire logic                              req_write,
  input  wire logic                              req_fetch,
  input  wire logic [ext_bus_pkg::ADDR_WIDTH-1:0] req_addr,
  input  wire logic [ext_bus_pkg::DATA_WIDTH-1:0] req_wdata,
  output logic                                   rsp_valid,
  output logic                                   rsp_internal,
  output logic      [ext_bus_pkg::DATA_WIDTH-1:0] rsp_rdata,
  input  wire logic [ext_bus_pkg::REG_ADDR_WIDTH-1:0] reg_addr,
  input  wire logic [7:0]                        reg_wdata,
  input  wire logic                              reg_write,
  input  wire logic                              reg_read,
  output logic      [7:0]                        reg_rdata,
  output logic                                   data_space_select_n,
  output logic                                   program_space_select_n,
  output logic                                   io_space_select_n,
  output logic                                   memory_strobe_n,
  output logic                                   io_strobe_n,
  output logic                                   read_not_write,
  output logic      [ext_bus_pkg::ADDR_WIDTH-1:0] address,
  output logic                                   control_oe,
  output logic      [ext_bus_pkg::DATA_WIDTH-1:0] data_out,
  input  wire logic [ext_bus_pkg::DATA_WIDTH-1:0] data_in,
  output logic                                   data_oe,
  output logic                                   bus_keeper_enable,
  input  wire logic                              ready,
  input  wire logic                              hold_n,
  output logic                                   hold_acknowledge_n,
  output logic                                   wait_complete_n,
  output logic                                   instruction_fetch_n,
  output logic                                   misc_oe,
  input  wire logic                              float_all_n,
  input  wire logic                              rom_map_select
);
  import ext_bus_pkg::*;

  state_t                    state;
  state_t                    next_state;
  logic                      rom_removed;
  logic [WAIT_WIDTH-1:0]     sw_waits;
  logic [1:0]                acc_space;
  logic                      acc_write;
  logic                      acc_fetch;
  logic [ADDR_WIDTH-1:0]     acc_addr;
  logic [1:0]                launch_space;
  logic                      launch_write;
  logic                      launch_fetch;
  logic [ADDR_WIDTH-1:0]     launch_addr;
  logic [DATA_WIDTH-1:0]     launch_wdata;
  logic                      launch;
  logic                      launch_hit;
  logic                      load;
  logic [WAIT_WIDTH-1:0]     wait_count;
  logic [WAIT_WIDTH-1:0]     wait_total;
  logic                      ready_q;
  logic                      done;

  // internal rom claims the upper program window unless removed
  function automatic logic rom_hit(input logic [1:0] space, input logic [ADDR_WIDTH-1:0] addr,
                                   input logic removed);
    rom_hit = space == SPACE_PROGRAM && !removed && addr[LOW_ADDR_WIDTH-1:0] >= ROM_BASE;
  endfunction

  // [RULE15] restart fetch at boot
  always_comb begin
    if (state == st_boot) begin
      launch = 1'b1;
      launch_space = SPACE_PROGRAM;
      launch_write = 1'b0;
      launch_fetch = 1'b1;
      launch_addr = RESTART_ADDR;
      launch_wdata = '0;
      // [RULE16] strap decides rom mapping
      launch_hit = rom_hit(SPACE_PROGRAM, RESTART_ADDR, rom_map_select);
    end else begin
      launch = state == st_idle && req_valid && hold_n;
      launch_space = req_space;
      launch_write = req_write;
      launch_fetch = req_fetch && req_space == SPACE_PROGRAM;
      launch_addr = req_addr;
      launch_wdata = req_wdata;
      launch_hit = rom_hit(req_space, req_addr, rom_removed);
    end
  end

  assign req_ready = state == st_idle && hold_n;
  assign load = launch && !launch_hit;

  always_comb begin
    next_state = state;
    case (state)
      st_boot: begin
        next_state = launch_hit ? st_idle : st_access;
      end
      st_idle: begin
        // [RULE22] hold only between accesses
        if (!hold_n) begin
          next_state = st_hold;
        end else if (load) begin
          next_state = st_access;
        end
      end
      st_access: begin
        // [RULE5] stretch while not ready
        if (done) begin
          next_state = st_idle;
        end
      end
      st_hold: begin
        // [RULE9] release when hold drops
        if (hold_n) begin
          next_state = st_idle;
        end
      end
      default: begin
        next_state = st_idle;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= st_boot;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_space <= SPACE_DATA;
      acc_write <= 1'b0;
      acc_fetch <= 1'b0;
      acc_addr <= '0;
    end else if (load) begin
      acc_space <= launch_space;
      acc_write <= launch_write;
      acc_fetch <= launch_fetch;
      acc_addr <= launch_addr;
    end
  end

  wait_state_counter waits (
    .core_clk        (core_clk),
    .rst_n           (rst_n),
    .load            (load),
    .load_value      (sw_waits),
    .active          (state == st_access),
    .ready           (ready),
    .wait_count      (wait_count),
    .wait_total      (wait_total),
    .ready_q         (ready_q),
    .wait_complete_n (wait_complete_n),
    .done            (done)
  );

  function automatic logic [1:0] next_space();
    next_space = load ? launch_space : acc_space;
  endfunction

  // pins follow the next state, so they match state in each cycle
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      data_space_select_n <= 1'b1;
      program_space_select_n <= 1'b1;
      io_space_select_n <= 1'b1;
      memory_strobe_n <= 1'b1;
      io_strobe_n <= 1'b1;
    end else begin
      // [RULE1] one select per access
      data_space_select_n <= !(next_state == st_access && next_space() == SPACE_DATA);
      program_space_select_n <= !(next_state == st_access && next_space() == SPACE_PROGRAM);
      io_space_select_n <= !(next_state == st_access && next_space() == SPACE_IO);
      // [RULE2] memory strobe for memory
      memory_strobe_n <= !(next_state == st_access && next_space() != SPACE_IO);
      // [RULE3] io strobe for io
      io_strobe_n <= !(next_state == st_access && next_space() == SPACE_IO);
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      read_not_write <= 1'b1;
      instruction_fetch_n <= 1'b1;
    end else begin
      // [RULE4] low only for writes
      read_not_write <= !(next_state == st_access && (load ? launch_write : acc_write));
      // [RULE14] fetch marks instruction address
      instruction_fetch_n <= !(next_state == st_access && (load ? launch_fetch : acc_fetch));
    end
  end

  // [RULE18] upper lines for program only
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      address <= '0;
      data_out <= '0;
    end else if (load) begin
      address <= {launch_space == SPACE_PROGRAM ? launch_addr[ADDR_WIDTH-1:LOW_ADDR_WIDTH] : 7'h00,
                  launch_addr[LOW_ADDR_WIDTH-1:0]};
      data_out <= launch_wdata;
    end
  end

  // [RULE11] high through reset
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_acknowledge_n <= 1'b1;
    end else begin
      // [RULE10] acknowledge only in hold
      hold_acknowledge_n <= next_state != st_hold;
    end
  end

  pin_float_gate gate (
    .float_all_n  (float_all_n),
    .rst_n        (rst_n),
    .hold_active  (state == st_hold),
    .data_driving (state == st_access && acc_write),
    .control_oe   (control_oe),
    .misc_oe      (misc_oe),
    .data_oe      (data_oe)
  );

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rsp_valid <= 1'b0;
      rsp_internal <= 1'b0;
      rsp_rdata <= '0;
    end else begin
      rsp_valid <= done || (launch && launch_hit);
      rsp_internal <= launch && launch_hit;
      if (done && !acc_write) begin
        rsp_rdata <= data_in;
      end
    end
  end

  // strap is caught at the first edge after release, never under reset
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rom_removed <= 1'b0;
    end else if (state == st_boot) begin
      // [RULE16] latch strap at reset
      rom_removed <= rom_map_select;
    end else if (reg_write && reg_addr == MODE_STATUS_OFFSET) begin
      // [RULE17] software override
      rom_removed <= reg_wdata[MODE_ROM_REMOVED_BIT];
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sw_waits <= WAIT_RESET;
    end else if (reg_write && reg_addr == MODE_STATUS_OFFSET) begin
      sw_waits <= reg_wdata[MODE_WAIT_LSB +: WAIT_WIDTH];
    end
  end

  // [RULE20] keepers off at reset
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_keeper_enable <= KEEPER_RESET;
    end else if (reg_write && reg_addr == BANK_CONTROL_OFFSET) begin
      bus_keeper_enable <= reg_wdata[BANK_KEEPER_BIT];
    end
  end

  // unmapped offsets read zero
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= '0;
    end else if (reg_read) begin
      reg_rdata <= '0;
      case (reg_addr)
        MODE_STATUS_OFFSET: begin
          reg_rdata[MODE_ROM_REMOVED_BIT] <= rom_removed;
          reg_rdata[MODE_WAIT_LSB +: WAIT_WIDTH] <= sw_waits;
        end
        BANK_CONTROL_OFFSET: begin
          reg_rdata[BANK_KEEPER_BIT] <= bus_keeper_enable;
        end
        BUS_STATUS_OFFSET: begin
          reg_rdata[STATUS_HOLD_BIT] <= state == st_hold;
          reg_rdata[STATUS_BUSY_BIT] <= state == st_access;
          reg_rdata[STATUS_STRAP_BIT] <= rom_map_select;
        end
        default: begin
          reg_rdata <= '0;
        end
      endcase
    end else begin
      reg_rdata <= '0;
    end
  end

  one_select_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [RULE21]
    !data_space_select_n |-> !memory_strobe_n && program_space_select_n && io_space_select_n)
    else $error("data select without its strobe or with another select");

  io_select_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [RULE3]
    !io_space_select_n |-> !io_strobe_n && memory_strobe_n && program_space_select_n)
    else $error("io select without io strobe");

  write_dir_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [RULE4]
    !read_not_write |-> state == st_access && acc_write && data_oe == float_all_n)
    else $error("write direction outside a write");

  ready_skip_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [RULE6]
    (state == st_access && wait_total < READY_MIN_WAITS && wait_count == 3'h0) |=> state != st_access)
    else $error("short access waited on ready");

  msc_last_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [RULE7]
    $fell(wait_complete_n) |-> state == st_access && wait_count == 3'h1 && wait_total >= READY_MIN_WAITS)
    else $error("wait complete outside the last wait");

  ready_stall_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [RULE5]
    (state == st_access && wait_total >= READY_MIN_WAITS && wait_count == 3'h0 && !ready_q)
    |=> state == st_access && !memory_strobe_n || !io_strobe_n)
    else $error("access ended while not ready");

  hold_boundary_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [RULE22]
    (state == st_hold && $past(state) != st_hold) |-> $past(state) == st_idle && !hold_acknowledge_n)
    else $error("hold entered mid access");

  hold_float_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [RULE12]
    !hold_acknowledge_n |-> !control_oe && !data_oe && memory_strobe_n && io_strobe_n)
    else $error("lines driven in hold");

  float_all_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [RULE13]
    !float_all_n |-> !control_oe && !misc_oe && !data_oe)
    else $error("pin driven while float-all low");

  fetch_program_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [RULE14]
    !instruction_fetch_n |-> !program_space_select_n)
    else $error("instruction fetch outside program space");

  boot_fetch_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [RULE15]
    (state == st_boot && !rom_map_select == 1'b0) |=> address == RESTART_ADDR && !program_space_select_n)
    else $error("first fetch not at restart address");

  keeper_off_a: assert property (@(posedge core_clk) // [RULE20]
    $rose(rst_n) |-> bus_keeper_enable == KEEPER_RESET)
    else $error("bus keepers not off after reset");

endmodule // external_memory_bus_interface
`default_nettype wire

// file: logic/pin_float_gate.sv
// output enables for the bus pins from hold, float-all and reset
// assumes all inputs are synchronous levels
`timescale 1ns/10ps
`default_nettype none
module pin_float_gate (
  input  wire logic float_all_n,
  input  wire logic rst_n,
  input  wire logic hold_active,
  input  wire logic data_driving,
  output logic      control_oe,
  output logic      misc_oe,
  output logic      data_oe
);

  always_comb begin
    // [RULE12] hold floats control
    control_oe = float_all_n && !hold_active;
    // [RULE13] float-all floats everything
    misc_oe = float_all_n;
    // [RULE19] data floats unless writing
    data_oe = float_all_n && rst_n && !hold_active && data_driving;
  end

endmodule // pin_float_gate
`default_nettype wire

// file: logic/wait_state_counter.sv
// software wait counter with ready sampling and wait-complete strobe
// assumes ready is synchronous to core_clk
`timescale 1ns/10ps
`default_nettype none
module wait_state_counter
  import ext_bus_pkg::*;
(
  input  wire logic                  core_clk,
  input  wire logic                  rst_n,
  input  wire logic                  load,
  input  wire logic [WAIT_WIDTH-1:0] load_value,
  input  wire logic                  active,
  input  wire logic                  ready,
  output logic      [WAIT_WIDTH-1:0] wait_count,
  output logic      [WAIT_WIDTH-1:0] wait_total,
  output logic                       ready_q,
  output logic                       wait_complete_n,
  output logic                       done
);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_count <= '0;
    end else if (load) begin
      wait_count <= load_value;
    end else if (active && wait_count != '0) begin
      wait_count <= wait_count - 3'h1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_total <= '0;
    end else if (load) begin
      wait_total <= load_value;
    end
  end

  // one cycle of sampling lag gives the re-check after a low ready
  // [RULE8] looped wait-complete adds one
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ready_q <= 1'b1;
    end else begin
      ready_q <= ready;
    end
  end

  // [RULE7] low in last wait
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_complete_n <= 1'b1;
    end else begin
      wait_complete_n <= !(active && wait_total >= READY_MIN_WAITS && wait_count == 3'h2);
    end
  end

  // [RULE6] ready ignored below two
  always_comb begin
    if (wait_total < READY_MIN_WAITS) begin
      done = active && wait_count == '0;
    end else begin
      done = active && wait_count == '0 && ready_q;
    end
  end

endmodule // wait_state_counter
`default_nettype wire

// file: shared/ext_bus_pkg.sv
// constants shared by the external memory bus interface and its helpers
// assumes one core clock domain at 25 MHz and an active-low asynchronous reset
package ext_bus_pkg;

  localparam int ADDR_WIDTH = 23;
  localparam int LOW_ADDR_WIDTH = 16;
  localparam int DATA_WIDTH = 16;
  localparam int WAIT_WIDTH = 3;
  localparam int REG_ADDR_WIDTH = 4;

  // space codes on the core request port
  localparam logic [1:0] SPACE_DATA = 2'h0;
  localparam logic [1:0] SPACE_PROGRAM = 2'h1;
  localparam logic [1:0] SPACE_IO = 2'h2;

  // register offsets
  localparam logic [REG_ADDR_WIDTH-1:0] MODE_STATUS_OFFSET = 4'h0;
  localparam logic [REG_ADDR_WIDTH-1:0] BANK_CONTROL_OFFSET = 4'h1;
  localparam logic [REG_ADDR_WIDTH-1:0] BUS_STATUS_OFFSET = 4'h2;

  // processor_mode_status fields
  localparam int MODE_ROM_REMOVED_BIT = 0;
  localparam int MODE_WAIT_LSB = 1;
  localparam logic [WAIT_WIDTH-1:0] WAIT_RESET = 3'h7;

  // bank_switch_control fields
  localparam int BANK_KEEPER_BIT = 0;
  localparam logic KEEPER_RESET = 1'b0;

  // bus status fields
  localparam int STATUS_HOLD_BIT = 0;
  localparam int STATUS_BUSY_BIT = 1;
  localparam int STATUS_STRAP_BIT = 2;

  // restart address and internal rom window
  localparam logic [ADDR_WIDTH-1:0] RESTART_ADDR = 23'h00ff80;
  localparam logic [LOW_ADDR_WIDTH-1:0] ROM_BASE = 16'hf000;

  // least software wait count that makes ready count
  localparam logic [WAIT_WIDTH-1:0] READY_MIN_WAITS = 3'h2;

  typedef enum logic [1:0] {st_boot, st_idle, st_access, st_hold} state_t;

endpackage

// file: test/ext_memory_model.sv
// external memory model answering the bus interface
// assumes the bench picks ready behaviour through ready_mode
`timescale 1ns/10ps
`default_nettype none
module ext_memory_model #(
  parameter int STALL = 5
) (
  input  wire logic        core_clk,
  input  wire logic        strobe_n,
  input  wire logic        read_not_write,
  input  wire logic [22:0] address,
  input  wire logic [15:0] data_out,
  input  wire logic        drive,
  input  wire logic        wait_complete_n,
  input  wire logic [1:0]  ready_mode,
  output logic      [15:0] data_in,
  output logic             ready
);
  logic [15:0] mem [16];
  logic [15:0] last = 16'h5a5a;
  logic [3:0]  busy = 4'h0;
  wire         act  = !strobe_n && drive;
  // released bus shows a changing pattern, never a stale word
  assign data_in = (act && read_not_write) ? mem[address[3:0]] : ~last;
  always_ff @(posedge core_clk) begin
    last <= data_in;
    busy <= act ? busy + 4'h1 : 4'h0;
    if (act && !read_not_write)
      mem[address[3:0]] <= data_out;
  end
  assign ready = (ready_mode == 2'h1) ? wait_complete_n : ((ready_mode == 2'h2) ? (busy >= STALL) : 1'b1);
endmodule // ext_memory_model
`default_nettype wire

// file: test/external_memory_bus_interface_bench.sv
// self-checking bench for the external memory bus interface
// assumes ext_memory_model answers the bus side
`timescale 1ns/10ps
`default_nettype none
module external_memory_bus_interface_bench;
  import ext_bus_pkg::*;
  logic        core_clk, rst_n, req_valid, req_ready, req_write, req_fetch, rsp_valid, rsp_internal;
  logic [1:0]  req_space, ready_mode;
  logic [22:0] req_addr, address;
  logic [15:0] req_wdata, rsp_rdata, data_out, data_in;
  logic [3:0]  reg_addr;
  logic [7:0]  reg_wdata, reg_rdata;
  logic        reg_write, reg_read, data_space_select_n, program_space_select_n, io_space_select_n;
  logic        memory_strobe_n, io_strobe_n, read_not_write, control_oe, data_oe, bus_keeper_enable, ready;
  logic        hold_n, hold_acknowledge_n, wait_complete_n, instruction_fetch_n, misc_oe, float_all_n;
  logic        rom_map_select, hold_mid;
  int          n_fail, check_count, cycles, wc, n_clk;
  logic [2:0]  tw [4] = '{3'h1, 3'h3, 3'h3, 3'h2};
  logic [1:0]  tm [4] = '{2'h2, 2'h0, 2'h1, 2'h2};
  int          tc [4] = '{2, 4, 5, 7};

  external_memory_bus_interface dut (.*);
  ext_memory_model mem (
    .core_clk       (core_clk),
    .strobe_n       (memory_strobe_n & io_strobe_n),
    .read_not_write (read_not_write),
    .address        (address),
    .data_out       (data_out),
    .drive          (control_oe),
    .wait_complete_n(wait_complete_n),
    .ready_mode     (ready_mode),
    .data_in        (data_in),
    .ready          (ready)
  );

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // hang guard, far above the hundred or so cycles needed
  always @(posedge core_clk) begin
    n_clk++;
    if (n_clk == 3000) begin
      n_fail++;
      end_of_test;
    end
  end

  task automatic chk(input logic [22:0] got, input logic [22:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_write <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_write <= 1'b0;
  endtask

  task automatic reg_rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge core_clk);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_read <= 1'b0;
    #1;
    chk(23'(reg_rdata), 23'(e));
  endtask

  // sample each cycle until the response; pins checked in every bus cycle
  task automatic watch(input logic [1:0] sp, input logic wr, input logic f, input logic [22:0] ea);
    int         n;
    logic [8:0] pins;
    logic [8:0] ep;
    ep = {sp != SPACE_DATA, sp != SPACE_PROGRAM, sp != SPACE_IO, sp == SPACE_IO, sp != SPACE_IO, !wr, !f, wr, 1'b1};
    cycles = 0;
    wc = 0;
    for (n = 0; n < 40; n++) begin
      #1;
      if (rsp_valid === 1'b1)
        break;
      pins = {data_space_select_n, program_space_select_n, io_space_select_n, memory_strobe_n, io_strobe_n,
              read_not_write, instruction_fetch_n, data_oe, hold_acknowledge_n};
      if ((pins[8] & pins[7] & pins[6]) === 1'b0) begin
        cycles++;
        wc += int'(wait_complete_n === 1'b0);
        chk(23'(pins), 23'(ep));
        chk(address, ea);
      end
      @(posedge core_clk);
      if (hold_mid && n == 0)
        hold_n <= 1'b0;
    end
    chk(23'(n < 40), 23'h1);
  endtask

  task automatic acc(input logic [1:0] sp, input logic wr, input logic [22:0] a, input logic [15:0] d);
    @(posedge core_clk);
    req_valid <= 1'b1;
    req_space <= sp;
    req_write <= wr;
    req_fetch <= (sp == SPACE_PROGRAM) && !wr;
    req_addr  <= a;
    req_wdata <= d;
    #1;
    chk(23'(req_ready), 23'h1);
    @(posedge core_clk);
    req_valid <= 1'b0;
    watch(sp, wr, (sp == SPACE_PROGRAM) && !wr, (sp == SPACE_PROGRAM) ? a : {7'h0, a[15:0]});
  endtask

  task automatic restart(input logic strap);
    @(posedge core_clk);
    rst_n          <= 1'b0;
    rom_map_select <= strap;
    repeat (5) @(posedge core_clk);
    #1;
    chk({17'h0, hold_acknowledge_n, data_space_select_n, program_space_select_n, io_space_select_n,
         memory_strobe_n, read_not_write}, 23'h3f);
    @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    watch(SPACE_PROGRAM, 1'b0, 1'b1, RESTART_ADDR);
    chk(23'(cycles), strap ? 23'h8 : 23'h0);
    chk(23'(rsp_internal), 23'(!strap));
    reg_rd(MODE_STATUS_OFFSET, {4'h0, WAIT_RESET, strap});
  endtask

  task automatic hold_cycle(input logic busy);
    int n;
    if (!busy) begin
      @(posedge core_clk);
      hold_n <= 1'b0;
    end
    for (n = 0; n < 6 && hold_acknowledge_n !== 1'b0; n++) begin
      @(posedge core_clk);
      #1;
    end
    chk({19'h0, hold_acknowledge_n, control_oe, data_oe, misc_oe}, 23'h1);
    @(posedge core_clk);
    hold_n <= 1'b1;
    @(posedge core_clk);
    #1;
    chk({21'h0, hold_acknowledge_n, control_oe}, 23'h3);
  endtask

  initial begin
    {rst_n, req_valid, req_space, req_write, req_fetch, req_addr, req_wdata} = '0;
    {reg_addr, reg_wdata, reg_write, reg_read, ready_mode, hold_mid} = '0;
    {hold_n, float_all_n, rom_map_select} = 3'h7;
    restart(1'b1);
    reg_rd(BANK_CONTROL_OFFSET, 8'h00);
    reg_rd(4'h7, 8'h00);
    reg_wr(BANK_CONTROL_OFFSET, 8'h01);
    #1;
    chk(23'(bus_keeper_enable), 23'h1);
    reg_rd(BUS_STATUS_OFFSET, 8'h04);
    $display("reset and registers done");
    reg_wr(MODE_STATUS_OFFSET, 8'h01);
    acc(SPACE_DATA, 1'b1, 23'h4a0003, 16'h1234);
    acc(SPACE_IO, 1'b1, 23'h000005, 16'hbeef);
    acc(SPACE_PROGRAM, 1'b0, 23'h4a0003, 16'h0);
    chk(23'(rsp_rdata), 23'h1234);
    acc(SPACE_IO, 1'b0, 23'h000005, 16'h0);
    chk(23'(rsp_rdata), 23'hbeef);
    $display("spaces done");
    for (int i = 0; i < 4; i++) begin
      reg_wr(MODE_STATUS_OFFSET, {4'h0, tw[i], 1'b1});
      ready_mode <= tm[i];
      acc(SPACE_DATA, 1'b0, 23'h000003, 16'h0);
      chk(23'(cycles), 23'(tc[i]));
      chk(23'(wc), 23'(tw[i] > 3'h1));
    end
    $display("wait states done");
    ready_mode <= 2'h0;
    hold_cycle(1'b0);
    hold_mid = 1'b1;
    acc(SPACE_DATA, 1'b0, 23'h000005, 16'h0);
    hold_mid = 1'b0;
    hold_cycle(1'b1);
    @(posedge core_clk);
    float_all_n <= 1'b0;
    #1;
    chk({20'h0, control_oe, misc_oe, data_oe}, 23'h0);
    @(posedge core_clk);
    float_all_n <= 1'b1;
    $display("hold and float done");
    reg_wr(MODE_STATUS_OFFSET, 8'h00);
    acc(SPACE_PROGRAM, 1'b0, 23'h00f010, 16'h0);
    chk({21'h0, rsp_internal, cycles == 0}, 23'h3);
    restart(1'b0);
    rom_map_select <= 1'b1;
    reg_rd(MODE_STATUS_OFFSET, {4'h0, WAIT_RESET, 1'b0});
    $display("rom mapping done");
    end_of_test;
  end
endmodule // external_memory_bus_interface_bench
`default_nettype wire
